// >>> fftsc_pkg.sv
// Package: constants, states and carriers for the transform status block
package fftsc_pkg;
	localparam int ADDR_W = 10;
	localparam int CNT_W = 13;
	localparam logic [CNT_W-1:0] FRAME_CYCLES = 13'h0400;
	localparam int CALC_CYCLES_DEF = 5120;
	localparam logic [CNT_W-1:0] MODE_LEAD = 13'h0004;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_INT_STAT = 8'h08;
	localparam logic [7:0] OFF_INT_MASK = 8'h0C;
	localparam int CTRL_START = 0;
	localparam int CTRL_HALT = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_CFG = 1;
	localparam int ST_DIR = 3;
	localparam int ST_SCALE = 4;
	localparam int ST_BANK = 5;
	localparam int ST_FSM = 6;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_PRE = 1;
	localparam int IRQ_CAP = 2;
	localparam int IRQ_BADCFG = 3;
	localparam int IRQ_W = 4;
	localparam logic [IRQ_W-1:0] INT_MASK_RST = 4'h0;
	localparam logic [1:0] CTRL_RST = 2'h0;

	typedef enum logic [1:0] {
		CFG_INVALID = 2'b00,
		CFG_SINGLE = 2'b01,
		CFG_TRIPLE = 2'b10,
		CFG_DUAL = 2'b11
	} fftsc_cfg_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_LEAD = 2'b01,
		S_CALC = 2'b10,
		S_OUT = 2'b11
	} fftsc_state_t;

	typedef struct packed {
		logic working_we;
		logic x_a_we;
		logic x_b_we;
		logic y_a_we;
		logic y_b_we;
		logic x_a_en;
		logic y_a_en;
		logic bank;
	} fftsc_mem_t;

	localparam fftsc_mem_t MEM_RST = 8'h00;
endpackage

// >>> fftsc_sync.sv
// Two-stage synchroniser for slow pins
`timescale 1ns/1ps
`default_nettype none
module fftsc_sync #(
	parameter int W = 2
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;
endmodule
`default_nettype wire

// >>> fftsc_addr.sv
// Address generator: read address counter and write address one cycle behind
`timescale 1ns/1ps
`default_nettype none
module fftsc_addr (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_clear,
	input wire logic i_step,
	output logic [fftsc_pkg::ADDR_W-1:0] o_rd_addr,
	output logic [fftsc_pkg::ADDR_W-1:0] o_wr_addr
);
	logic [fftsc_pkg::ADDR_W-1:0] rd_reg;
	logic [fftsc_pkg::ADDR_W-1:0] rd_next;
	logic [fftsc_pkg::ADDR_W-1:0] wr_reg;

	assign rd_next = i_clear ? '0 :
		i_step ? rd_reg + 10'h001 : rd_reg;

	// Write address trails read by one cycle to match memory read latency
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			rd_reg <= '0;
			wr_reg <= '0;
		end else if (i_ce) begin
			rd_reg <= rd_next;
			wr_reg <= rd_reg;
		end
	end

	assign o_rd_addr = rd_reg;
	assign o_wr_addr = wr_reg;
endmodule
`default_nettype wire

// >>> fftsc_core.sv
// Transform status strobes, memory control and APB register block
`timescale 1ns/1ps
`default_nettype none
module fftsc_core #(
	parameter int CALC_CYCLES = fftsc_pkg::CALC_CYCLES_DEF
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_start,
	input wire logic i_transform_direction_select,
	input wire logic i_scale_select,
	input wire logic i_io_mode0,
	input wire logic i_io_mode1,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_irq,
	output logic o_done,
	output logic o_pre_frame_pulse,
	output logic o_burst_transfer_strobe,
	output logic o_early_burst_transfer_strobe,
	output logic o_busy,
	output logic o_mode_capture,
	output logic o_frame,
	output logic o_direction,
	output logic o_scale,
	output logic o_working_mem_port_a_write_en,
	output logic o_x_mem_port_a_write_en,
	output logic o_x_mem_port_b_write_en,
	output logic o_y_mem_port_a_write_en,
	output logic o_y_mem_port_b_write_en,
	output logic o_x_mem_port_a_enable,
	output logic o_y_mem_port_a_enable,
	output logic o_bank_select,
	output logic [9:0] o_x_mem_read_address,
	output logic [9:0] o_x_mem_write_address,
	output logic [9:0] o_y_mem_read_address
);
	localparam logic [12:0] CALC_LAST = 13'(CALC_CYCLES - 1);

	fftsc_pkg::fftsc_state_t state_reg;
	fftsc_pkg::fftsc_state_t state_next;
	fftsc_pkg::fftsc_cfg_t cfg;
	fftsc_pkg::fftsc_mem_t mem_reg;
	fftsc_pkg::fftsc_mem_t mem_next;
	logic [1:0] mode_sync;
	logic [12:0] cnt_reg;
	logic [12:0] cnt_next;
	logic dir_reg;
	logic scale_reg;
	logic [1:0] ctrl_reg;
	logic start_pulse_reg;
	logic [3:0] int_stat_reg;
	logic [3:0] int_mask_reg;
	logic [3:0] int_event;
	logic [31:0] prdata_reg;
	logic bank_reg;

	fftsc_sync #(
		.W(2)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_async({i_io_mode0, i_io_mode1}),
		.o_sync(mode_sync)
	);

	assign cfg = fftsc_pkg::fftsc_cfg_t'(mode_sync);

	// Sequencer decode
	wire is_single = (cfg == fftsc_pkg::CFG_SINGLE);
	wire is_dual = (cfg == fftsc_pkg::CFG_DUAL);
	wire is_triple = (cfg == fftsc_pkg::CFG_TRIPLE);
	wire is_cont = is_dual | is_triple;
	wire st_idle = (state_reg == fftsc_pkg::S_IDLE);
	wire st_lead = (state_reg == fftsc_pkg::S_LEAD);
	wire st_calc = (state_reg == fftsc_pkg::S_CALC);
	wire st_out = (state_reg == fftsc_pkg::S_OUT);
	wire cnt_zero = (cnt_reg == 13'h0000);
	wire start_req = i_start | start_pulse_reg;
	wire start_ok = st_idle & start_req & (cfg != fftsc_pkg::CFG_INVALID);
	wire start_bad = st_idle & start_req & (cfg == fftsc_pkg::CFG_INVALID);
	wire mode_cap = st_lead & (cnt_reg == fftsc_pkg::MODE_LEAD - 13'h0001);
	wire halt = ctrl_reg[fftsc_pkg::CTRL_HALT];

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_zero ? cnt_reg : cnt_reg - 13'h0001;
		unique case (state_reg)
			fftsc_pkg::S_IDLE: begin
				if (start_ok && is_single) begin
					state_next = fftsc_pkg::S_CALC;
					cnt_next = CALC_LAST;
				end else if (start_ok) begin
					state_next = fftsc_pkg::S_LEAD;
					cnt_next = fftsc_pkg::MODE_LEAD - 13'h0001;
				end
			end
			fftsc_pkg::S_LEAD: begin
				if (cnt_zero) begin
					state_next = fftsc_pkg::S_CALC;
					cnt_next = CALC_LAST;
				end
			end
			fftsc_pkg::S_CALC: begin
				if (cnt_zero) begin
					state_next = fftsc_pkg::S_OUT;
					cnt_next = fftsc_pkg::FRAME_CYCLES - 13'h0001;
				end
			end
			fftsc_pkg::S_OUT: begin
				if (cnt_zero && is_cont && !halt) begin
					state_next = fftsc_pkg::S_LEAD;
					cnt_next = fftsc_pkg::MODE_LEAD - 13'h0001;
				end else if (cnt_zero) begin
					state_next = fftsc_pkg::S_IDLE;
				end
			end
		endcase
	end

	// State and counter advance only while the clock enable is high
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			state_reg <= fftsc_pkg::S_IDLE;
			cnt_reg <= '0;
		end else if (i_ce) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// Operation mode capture
	wire dir_next = (start_ok | mode_cap) ?
		i_transform_direction_select : dir_reg;
	wire scale_next = (start_ok | mode_cap) ? i_scale_select : scale_reg;

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			dir_reg <= 1'b0;
			scale_reg <= 1'b0;
		end else if (i_ce) begin
			dir_reg <= dir_next;
			scale_reg <= scale_next;
		end
	end

	// Status strobes
	assign o_frame = st_out;
	assign o_done = st_out & cnt_zero;
	assign o_pre_frame_pulse = st_calc & cnt_zero;
	assign o_burst_transfer_strobe = is_dual & st_out;
	assign o_early_burst_transfer_strobe = is_dual & o_pre_frame_pulse;
	assign o_busy = !st_idle;
	assign o_mode_capture = mode_cap;
	assign o_direction = dir_reg;
	assign o_scale = scale_reg;

	// Memory control
	wire bank_next = (is_triple & o_done) ? !bank_reg : bank_reg;
	always_comb begin
		mem_next = fftsc_pkg::MEM_RST;
		mem_next.working_we = is_single & st_calc;
		mem_next.x_a_we = is_cont & st_calc;
		mem_next.x_b_we = is_dual & st_out;
		mem_next.y_a_we = is_triple & st_calc & bank_reg;
		mem_next.y_b_we = is_cont & st_out;
		mem_next.x_a_en = !st_idle;
		mem_next.y_a_en = is_triple & !st_idle;
		mem_next.bank = bank_next;
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			mem_reg <= fftsc_pkg::MEM_RST;
			bank_reg <= 1'b0;
		end else if (i_ce) begin
			mem_reg <= mem_next;
			bank_reg <= bank_next;
		end
	end

	assign o_working_mem_port_a_write_en = mem_reg.working_we;
	assign o_x_mem_port_a_write_en = mem_reg.x_a_we;
	assign o_x_mem_port_b_write_en = mem_reg.x_b_we;
	assign o_y_mem_port_a_write_en = mem_reg.y_a_we;
	assign o_y_mem_port_b_write_en = mem_reg.y_b_we;
	assign o_x_mem_port_a_enable = mem_reg.x_a_en;
	assign o_y_mem_port_a_enable = mem_reg.y_a_en;
	assign o_bank_select = mem_reg.bank;

	fftsc_addr u_addr (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_ce(i_ce),
		.i_clear(st_idle | st_lead | o_pre_frame_pulse),
		.i_step(st_calc | st_out),
		.o_rd_addr(o_x_mem_read_address),
		.o_wr_addr(o_x_mem_write_address)
	);

	// Y read address mirrors X in continuous configs, else parked at zero
	assign o_y_mem_read_address = is_cont ? o_x_mem_read_address : '0;

	// APB slave, zero wait states
	wire setup = i_psel & !i_penable;
	wire access = i_psel & i_penable;
	wire hit_ctrl = (i_paddr == fftsc_pkg::OFF_CTRL);
	wire hit_status = (i_paddr == fftsc_pkg::OFF_STATUS);
	wire hit_istat = (i_paddr == fftsc_pkg::OFF_INT_STAT);
	wire hit_imask = (i_paddr == fftsc_pkg::OFF_INT_MASK);
	wire mapped = hit_ctrl | hit_status | hit_istat | hit_imask;
	wire wr = access & i_pwrite & mapped;
	wire [31:0] status_word = {24'h000000, state_reg, bank_reg, scale_reg,
		dir_reg, cfg, o_busy};
	wire [31:0] rd_mux = hit_ctrl ? {30'h00000000, ctrl_reg} :
		hit_status ? status_word :
		hit_istat ? {28'h0000000, int_stat_reg} :
		hit_imask ? {28'h0000000, int_mask_reg} : 32'h00000000;

	assign o_pready = 1'b1;
	assign o_pslverr = access & !mapped;
	assign o_prdata = prdata_reg;

	// Events are counted once per enabled cycle
	assign int_event[fftsc_pkg::IRQ_DONE] = o_done & i_ce;
	assign int_event[fftsc_pkg::IRQ_PRE] = o_pre_frame_pulse & i_ce;
	assign int_event[fftsc_pkg::IRQ_CAP] = mode_cap & i_ce;
	assign int_event[fftsc_pkg::IRQ_BADCFG] = start_bad & i_ce;

	wire [3:0] w1c = (wr & hit_istat) ? i_pwdata[3:0] : 4'h0;
	wire [3:0] int_stat_next = (int_stat_reg & ~w1c) | int_event;

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			ctrl_reg <= fftsc_pkg::CTRL_RST;
			start_pulse_reg <= 1'b0;
			int_stat_reg <= '0;
			int_mask_reg <= fftsc_pkg::INT_MASK_RST;
			prdata_reg <= '0;
		end else begin
			start_pulse_reg <= start_pulse_reg ? !i_ce :
				(wr & hit_ctrl & i_pwdata[fftsc_pkg::CTRL_START]);
			if (wr & hit_ctrl)
				ctrl_reg <= {i_pwdata[fftsc_pkg::CTRL_HALT], 1'b0};
			if (wr & hit_imask)
				int_mask_reg <= i_pwdata[3:0];
			int_stat_reg <= int_stat_next;
			if (setup)
				prdata_reg <= rd_mux;
		end
	end

	assign o_irq = |(int_stat_reg & int_mask_reg);

	sequence s_frame_ends;
		o_frame ##1 !o_frame;
	endsequence

	sequence s_frame_starts;
		!o_frame ##1 o_frame;
	endsequence

	property p_done_end;
		@(posedge i_ref_clk) disable iff (i_reset)
		(o_done && i_ce) |-> s_frame_ends;
	endproperty
	a_done_end: assert property (p_done_end)
		else $error("done not at end of frame");

	property p_pre_frame;
		@(posedge i_ref_clk) disable iff (i_reset)
		(o_pre_frame_pulse && i_ce) |-> s_frame_starts ##0 !o_pre_frame_pulse;
	endproperty
	a_pre_frame: assert property (p_pre_frame)
		else $error("pre-frame pulse not just before frame");

	property p_burst;
		@(posedge i_ref_clk) disable iff (i_reset)
		(o_burst_transfer_strobe || o_early_burst_transfer_strobe) |-> is_dual;
	endproperty
	a_burst: assert property (p_burst)
		else $error("burst strobe outside dual config");

	property p_busy;
		@(posedge i_ref_clk) disable iff (i_reset)
		(start_ok && i_ce) |=> o_busy [*4];
	endproperty
	a_busy: assert property (p_busy)
		else $error("busy did not follow start");

	// Capture leads compute by the rest of the lead phase
	sequence s_capture_run;
		(o_mode_capture && i_ce) ##1 i_ce [*3];
	endsequence

	sequence s_calc_begins;
		!st_calc ##1 st_calc;
	endsequence

	property p_capture_lead;
		@(posedge i_ref_clk) disable iff (i_reset)
		s_capture_run |-> s_calc_begins;
	endproperty
	a_capture_lead: assert property (p_capture_lead)
		else $error("capture pulse not ahead of compute");

	property p_capture_sample;
		@(posedge i_ref_clk) disable iff (i_reset)
		(o_mode_capture && i_ce) |=>
			(o_direction == $past(i_transform_direction_select))
			&& (o_scale == $past(i_scale_select));
	endproperty
	a_capture_sample: assert property (p_capture_sample)
		else $error("direction or scale not sampled at capture");

	property p_single_we;
		@(posedge i_ref_clk) disable iff (i_reset)
		$rose(o_working_mem_port_a_write_en) |-> $past(is_single && st_calc);
	endproperty
	a_single_we: assert property (p_single_we)
		else $error("working write enable outside single compute");

	property p_wr_addr;
		@(posedge i_ref_clk) disable iff (i_reset)
		$past(i_ce) |-> o_x_mem_write_address == $past(o_x_mem_read_address);
	endproperty
	a_wr_addr: assert property (p_wr_addr)
		else $error("write address does not trail read address");

	property p_freeze;
		@(posedge i_ref_clk) disable iff (i_reset)
		!i_ce |=> $stable(o_x_mem_read_address) && $stable(o_frame)
			&& $stable(o_x_mem_port_a_write_en);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("outputs moved with clock enable low");

	property p_bank_toggle;
		@(posedge i_ref_clk) disable iff (i_reset)
		i_ce |=> (o_bank_select != $past(o_bank_select))
			== $past(is_triple && o_done);
	endproperty
	a_bank_toggle: assert property (p_bank_toggle)
		else $error("bank select did not follow end of frame");

	// Checked from the second reset edge on, once the registers are cleared
	property p_reset_quiet;
		@(posedge i_ref_clk)
		(i_reset ##1 i_reset) |-> !o_busy && !o_done
			&& !o_pre_frame_pulse && !o_mode_capture
			&& !o_working_mem_port_a_write_en
			&& !o_x_mem_port_a_write_en && !o_x_mem_port_b_write_en
			&& !o_y_mem_port_a_write_en && !o_y_mem_port_b_write_en;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("strobes or write enables active in reset");
endmodule
`default_nettype wire

// >>> fftsc_ram_model.sv
// Memory bank model that records which X addresses were written
`timescale 1ns/1ps
`default_nettype none
module fftsc_ram_model (
	input wire logic i_ref_clk,
	input wire logic i_clear,
	input wire fftsc_pkg::fftsc_mem_t i_mem,
	input wire logic [9:0] i_wr_addr,
	output logic [10:0] o_written
);
	logic seen [1024];
	wire logic x_wr = i_mem.x_a_we | i_mem.x_b_we | i_mem.working_we;
	// Writes land at the edge, with the values set up before it
	always @(posedge i_ref_clk) begin
		if (i_clear) begin
			foreach (seen[i]) seen[i] <= 1'b0;
			o_written <= 11'h000;
		end else if (x_wr) begin
			o_written <= o_written + {10'h000, !seen[i_wr_addr]};
			seen[i_wr_addr] <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> fftsc_tb.sv
// Self-checking bench for the transform status and memory control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_ref_clk = 0, i_reset = 1, i_ce = 1, i_start = 0, clr = 0;
	logic dir = 1, scl = 1, m0 = 0, m1 = 1, err;
	logic i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, rd;
	wire logic [31:0] o_prdata;
	wire logic o_pready, o_pslverr, o_irq, o_done, o_pre_frame_pulse;
	wire logic burst, early, o_busy, o_mode_capture, o_frame;
	wire logic o_direction, o_scale;
	wire logic [9:0] xr, xw, yr;
	wire logic [10:0] written;
	wire fftsc_pkg::fftsc_mem_t mem;
	int mismatches = 0, total_checks = 0, c[15], e[15];

	fftsc_core #(.CALC_CYCLES(8)) dut (
		.i_ref_clk, .i_reset, .i_ce, .i_start,
		.i_transform_direction_select(dir), .i_scale_select(scl),
		.i_io_mode0(m0), .i_io_mode1(m1), .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_irq,
		.o_done, .o_pre_frame_pulse, .o_burst_transfer_strobe(burst),
		.o_early_burst_transfer_strobe(early), .o_busy, .o_mode_capture,
		.o_frame, .o_direction, .o_scale,
		.o_working_mem_port_a_write_en(mem.working_we),
		.o_x_mem_port_a_write_en(mem.x_a_we),
		.o_x_mem_port_b_write_en(mem.x_b_we),
		.o_y_mem_port_a_write_en(mem.y_a_we),
		.o_y_mem_port_b_write_en(mem.y_b_we),
		.o_x_mem_port_a_enable(mem.x_a_en),
		.o_y_mem_port_a_enable(mem.y_a_en),
		.o_bank_select(mem.bank), .o_x_mem_read_address(xr),
		.o_x_mem_write_address(xw), .o_y_mem_read_address(yr)
	);
	fftsc_ram_model ram (.i_ref_clk, .i_clear(clr), .i_mem(mem),
		.i_wr_addr(xw), .o_written(written));

	always #5 i_ref_clk = ~i_ref_clk;

	task automatic check(input bit ok, input int id);
		total_checks++;
		if (!ok) begin
			mismatches++;
			$display("Error at %0t ns: check %0d failed", $time, id);
		end
	endtask

	task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_psel <= 1;
		i_penable <= 0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1;
		@(posedge i_ref_clk);
		while (o_pready !== 1'b1) @(posedge i_ref_clk);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
		#1;
	endtask

	// Config pins pass a synchroniser, so let them settle
	task automatic cfg(input logic a, input logic b);
		@(posedge i_ref_clk);
		m0 <= a;
		m1 <= b;
		clr <= 1;
		repeat (4) @(posedge i_ref_clk);
		clr <= 0;
	endtask

	task automatic expect_c();
		foreach (e[i])
			if (e[i] > -2) check(e[i] < 0 ? c[i] > 0 : c[i] == e[i], i);
	endtask

	// md: [1:0] config pins, [2] freeze and late start, [3] flip modes
	task automatic run(input logic [3:0] md);
		logic [42:0] s, p;
		logic [14:0] f;
		bit pb, pf;
		p = '0;
		pb = 0;
		pf = 0;
		foreach (c[i]) c[i] = 0;
		@(posedge i_ref_clk);
		i_start <= 1;
		@(posedge i_ref_clk);
		i_start <= 0;
		if (md[3]) begin
			dir <= !dir;
			scl <= !scl;
		end
		for (int k = 0; k < 3000; k++) begin
			#1;
			s = {o_done, o_pre_frame_pulse, o_mode_capture, o_frame, o_busy,
				mem, xr, xw, yr};
			if (pf && s !== p) c[13]++;
			if (!pf) begin
				f = {mem.x_a_en, 1'b0, mem.y_a_en, mem.y_b_we, mem.y_a_we,
					mem.x_b_we, mem.x_a_we, mem.working_we,
					{early, burst, o_mode_capture, o_pre_frame_pulse, o_done,
					o_frame, 1'b1} & {7{o_busy}}};
				foreach (c[i]) c[i] += f[i];
				if (k > 0 && o_busy && xw !== p[29:20]) c[13]++;
				if (k > 0 && o_mode_capture) c[13]++;
				if (yr !== (md[1] ? xr : 10'h000)) c[13]++;
				if (p[42] && (o_frame || !p[39])) c[13]++;
				if (p[41] && (!o_frame || p[39])) c[13]++;
				if (!o_busy && !pb) break;
			end
			p = s;
			pb = o_busy;
			pf = !i_ce;
			@(posedge i_ref_clk);
			i_ce <= !(md[2] && k >= 20 && k < 25);
			i_start <= md[2] && k == 40;
		end
	endtask

	task automatic t_reset();
		repeat (10) @(posedge i_ref_clk);
		#1;
		check(o_busy === 1'b0 && o_done === 1'b0 && mem === 8'h00, 30);
		repeat (6) @(posedge i_ref_clk);
		i_reset <= 0;
		repeat (3) @(posedge i_ref_clk);
		apb(0, 8'h0C, 32'h0);
		check(rd === 32'h0 && err === 1'b0, 31);
		$display("reset test done");
	endtask

	task automatic t_single();
		apb(1, 8'h0C, 32'h1);
		run(4'b0101);
		e = '{1032, 1024, 1, 1, 0, 0, 0, -1, 0, 0, 0, 0, 0, 0, -1};
		expect_c();
		check(o_direction === 1'b1 && o_scale === 1'b1, 32);
		check(o_irq === 1'b1, 33);
		apb(0, 8'h08, 32'h0);
		check(rd[1:0] === 2'b11, 34);
		apb(1, 8'h08, 32'h3);
		check(o_irq === 1'b0, 35);
		$display("single test done");
	endtask

	task automatic t_dual();
		cfg(1, 1);
		apb(1, 8'h00, 32'h2);
		run(4'b1011);
		e = '{1036, 1024, 1, 1, 1, 1024, 1, 0, 8, 1024, 0, 1024, 0, 0, -1};
		expect_c();
		check(o_direction === 1'b0 && o_scale === 1'b0, 36);
		check(written === 11'h400, 37);
		$display("dual test done");
	endtask

	task automatic t_triple();
		cfg(1, 0);
		run(4'b0010);
		e = '{1036, 1024, 1, 1, 1, 0, 0, 0, 8, 0, 0, 1024, -2, 0, -1};
		expect_c();
		check(mem.bank === 1'b1, 38);
		run(4'b0010);
		e[10] = 8;
		e[12] = -1;
		expect_c();
		check(mem.bank === 1'b0, 39);
		$display("triple test done");
	endtask

	// Register start with no halt repeats; halt ends after the next frame
	task automatic t_cont();
		int n;
		cfg(1, 1);
		apb(1, 8'h00, 32'h1);
		n = 0;
		while (o_done !== 1'b1 && n < 1100) begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		check(n == 1036, 43);
		apb(1, 8'h00, 32'h2);
		check(o_busy === 1'b1 && o_frame === 1'b0, 44);
		n = 0;
		while (o_busy === 1'b1 && n < 1100) begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		check(n == 1034, 45);
		$display("repeat test done");
	endtask

	task automatic t_err();
		cfg(0, 0);
		apb(1, 8'h0C, 32'h8);
		run(4'b0000);
		check(c[0] == 0 && o_busy === 1'b0 && o_irq === 1'b1, 40);
		apb(0, 8'h10, 32'h0);
		check(rd === 32'h0 && err === 1'b1, 41);
		apb(1, 8'h08, 32'h8);
		check(o_irq === 1'b0, 42);
		$display("error test done");
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		t_reset();
		t_single();
		t_dual();
		t_triple();
		t_cont();
		t_err();
		finish_test();
	end

	// About 6300 cycles of traffic; cut off well beyond that
	initial begin
		#200000;
		mismatches++;
		finish_test();
	end
endmodule
`default_nettype wire
